// *** rtl/adcsp_pkg.sv ***
// shared constants and types of the serial configuration port
package adcsp_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 11;
   localparam int NUM_REGS = 8;
   localparam logic [3:0] BIT_COUNT_LAST = 4'hf;
   localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
   localparam logic [4:0] ADDR_RESET_CTRL = 5'h00;
   localparam logic [4:0] ADDR_CLK_GAIN = 5'h04;
   localparam logic [4:0] ADDR_FORMAT = 5'h0a;
   localparam logic [4:0] ADDR_PAT_LOW = 5'h0b;
   localparam logic [4:0] ADDR_GAIN_PAT_HIGH = 5'h0c;
   localparam logic [4:0] ADDR_OUT_OPTIONS = 5'h0d;
   localparam logic [4:0] ADDR_CLK_DRIVE = 5'h10;
   localparam logic [4:0] ADDR_DATA_DRIVE = 5'h11;
   localparam logic [2:0] SLOT_RESET_CTRL = 3'h0;
   localparam logic [2:0] SLOT_CLK_GAIN = 3'h1;
   localparam logic [2:0] SLOT_FORMAT = 3'h2;
   localparam logic [2:0] SLOT_PAT_LOW = 3'h3;
   localparam logic [2:0] SLOT_GAIN_PAT_HIGH = 3'h4;
   localparam logic [2:0] SLOT_OUT_OPTIONS = 3'h5;
   localparam logic [2:0] SLOT_CLK_DRIVE = 3'h6;
   localparam logic [2:0] SLOT_DATA_DRIVE = 3'h7;
   localparam logic [10:0] REG_RESET_VALUE = 11'h000;
   localparam int SOFT_RESET_BIT = 10;
   localparam int GLOBAL_PDN_BIT = 0;
   localparam int OVERRIDE_BIT = 10;
   localparam int MODE_LSB = 0;
   localparam int MODE_BYTE_WISE_BIT = 7;
   localparam int MODE_LSB_FIRST_BIT = 6;
   localparam int MODE_COARSE_GAIN_BIT = 5;
   localparam int MODE_RISE_CAPTURE_BIT = 4;
   localparam int MODE_SER16_BIT = 2;
   localparam int MODE_SDR_BIT = 1;
   localparam int MODE_TWO_WIRE_BIT = 0;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_EFFECT_NS = 100;
   localparam int WRITE_EFFECT_CYCLES = WRITE_EFFECT_NS / CLK_PERIOD_NS;
   localparam int RESET_PULSE_NS = 10;
   localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic enable_n;
      logic shift_clk;
      logic data;
   } adcsp_serial_pins_t;

   typedef struct packed {
      logic byte_wise;
      logic lsb_first;
      logic coarse_gain;
      logic rise_capture;
      logic ser16;
      logic sdr;
      logic two_wire;
   } adcsp_out_mode_t;

   typedef logic [DATA_W-1:0] adcsp_reg_word_t;

   // maps a serial address to a storage slot; valid is low for unmapped addresses
   function automatic logic [3:0] adcsp_addr_slot(input logic [4:0] addr);
      if (addr == ADDR_RESET_CTRL) begin
         return {1'b1, SLOT_RESET_CTRL};
      end else if (addr == ADDR_CLK_GAIN) begin
         return {1'b1, SLOT_CLK_GAIN};
      end else if (addr == ADDR_FORMAT) begin
         return {1'b1, SLOT_FORMAT};
      end else if (addr == ADDR_PAT_LOW) begin
         return {1'b1, SLOT_PAT_LOW};
      end else if (addr == ADDR_GAIN_PAT_HIGH) begin
         return {1'b1, SLOT_GAIN_PAT_HIGH};
      end else if (addr == ADDR_OUT_OPTIONS) begin
         return {1'b1, SLOT_OUT_OPTIONS};
      end else if (addr == ADDR_CLK_DRIVE) begin
         return {1'b1, SLOT_CLK_DRIVE};
      end else if (addr == ADDR_DATA_DRIVE) begin
         return {1'b1, SLOT_DATA_DRIVE};
      end else begin
         return 4'h0;
      end
   endfunction : adcsp_addr_slot

   // picks the output mode fields out of the output options word
   function automatic adcsp_out_mode_t adcsp_mode_fields(input adcsp_reg_word_t word);
      adcsp_out_mode_t m;
      m.byte_wise = word[MODE_BYTE_WISE_BIT];
      m.lsb_first = word[MODE_LSB_FIRST_BIT];
      m.coarse_gain = word[MODE_COARSE_GAIN_BIT];
      m.rise_capture = word[MODE_RISE_CAPTURE_BIT];
      m.ser16 = word[MODE_SER16_BIT];
      m.sdr = word[MODE_SDR_BIT];
      m.two_wire = word[MODE_TWO_WIRE_BIT];
      return m;
   endfunction : adcsp_mode_fields
endpackage : adcsp_pkg

// *** rtl/adcsp_input_sync.sv ***
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none
module adcsp_input_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] level_next;

   // a change counts once the second and third stages agree
   always_comb begin
      level_next = (stage2_reg & stage3_reg) | (level_reg & (stage2_reg ^ stage3_reg));
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         level_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule : adcsp_input_sync
`default_nettype wire

// *** rtl/adcsp_config_port.sv ***
// serial configuration port with register map and register reset logic
`timescale 1ns/10ps
`default_nettype none
module adcsp_config_port
   import adcsp_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire adcsp_serial_pins_t serial_pins_in,
   input wire logic hw_reset_in,
   input wire logic power_down_pin_in,
   input wire adcsp_out_mode_t pin_mode_in,
   output logic [NUM_REGS-1:0][DATA_W-1:0] config_regs_out,
   output adcsp_out_mode_t active_mode_out,
   output logic global_power_down_out,
   output logic write_commit_out
);
   localparam int SYNC_W = 3 + 1 + 7;
   localparam int EFFECT_MAX = WRITE_EFFECT_CYCLES;

   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic hw_catch_reg;
   logic hw_clear_reg;
   logic [SYNC_W-1:0] sync_level;
   adcsp_serial_pins_t pins_s;
   logic pdn_pin_s;
   adcsp_out_mode_t pin_mode_s;

   logic shift_clk_prev_reg;
   logic [15:0] shift_reg, shift_next;
   logic [3:0] bit_count_reg, bit_count_next;
   logic fall_edge;
   logic word_done;
   logic [15:0] word_now;
   logic [3:0] slot_hit;

   logic [NUM_REGS-1:0][DATA_W-1:0] regs_reg, regs_next;
   adcsp_out_mode_t mode_reg, mode_next;
   logic pdn_reg, pdn_next;
   logic commit_reg;
   logic [15:0] last_word_reg;

   // reset release through two flip-flops
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // short reset pin pulses are caught asynchronously, then retimed
   always_ff @(posedge clk_in or posedge hw_reset_in) begin
      if (hw_reset_in) begin
         hw_catch_reg <= 1'b1;
      end else begin
         hw_catch_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         hw_clear_reg <= 1'b0;
      end else begin
         hw_clear_reg <= hw_catch_reg;
      end
   end

   adcsp_input_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .async_in({serial_pins_in, power_down_pin_in, pin_mode_in}),
      .level_out(sync_level)
   );
   assign pins_s = sync_level[SYNC_W-1 -: 3];
   assign pdn_pin_s = sync_level[7];
   assign pin_mode_s = sync_level[6:0];

   // falling edge found on the filtered shift clock level
   assign fall_edge = shift_clk_prev_reg & ~pins_s.shift_clk & ~pins_s.enable_n;
   assign word_now = {shift_reg[14:0], pins_s.data};
   assign word_done = fall_edge && (bit_count_reg == BIT_COUNT_LAST);
   assign slot_hit = adcsp_addr_slot(word_now[15:11]);

   // shift path
   always_comb begin
      shift_next = shift_reg;
      bit_count_next = bit_count_reg;
      if (pins_s.enable_n) begin
         bit_count_next = BIT_COUNT_ZERO;
      end else if (fall_edge) begin
         shift_next = word_now;
         bit_count_next = bit_count_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         shift_clk_prev_reg <= 1'b0;
         shift_reg <= 16'h0000;
         bit_count_reg <= 4'h0;
      end else begin
         shift_clk_prev_reg <= pins_s.shift_clk;
         shift_reg <= shift_next;
         bit_count_reg <= bit_count_next;
      end
   end

   // register file and mode outputs
   always_comb begin
      regs_next = regs_reg;
      if (hw_clear_reg) begin
         regs_next = {NUM_REGS{REG_RESET_VALUE}};
      end else if (word_done && slot_hit[3]) begin
         if ((slot_hit[2:0] == SLOT_RESET_CTRL) && word_now[SOFT_RESET_BIT]) begin
            regs_next = {NUM_REGS{REG_RESET_VALUE}};
         end else begin
            regs_next[slot_hit[2:0]] = word_now[DATA_W-1:0];
         end
      end
      if (regs_next[SLOT_OUT_OPTIONS][OVERRIDE_BIT]) begin
         mode_next = adcsp_mode_fields(regs_next[SLOT_OUT_OPTIONS]);
      end else begin
         mode_next = pin_mode_s;
      end
      pdn_next = pdn_pin_s | regs_next[SLOT_RESET_CTRL][GLOBAL_PDN_BIT];
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         regs_reg <= {NUM_REGS{REG_RESET_VALUE}};
         mode_reg <= '0;
         pdn_reg <= 1'b0;
         commit_reg <= 1'b0;
         last_word_reg <= 16'h0000;
      end else begin
         regs_reg <= regs_next;
         mode_reg <= mode_next;
         pdn_reg <= pdn_next;
         commit_reg <= word_done;
         last_word_reg <= word_done ? word_now : last_word_reg;
      end
   end

   assign config_regs_out = regs_reg;
   assign active_mode_out = mode_reg;
   assign global_power_down_out = pdn_reg;
   assign write_commit_out = commit_reg;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);

   a_idle_count_clear: assert property (pins_s.enable_n |=> bit_count_reg == 4'h0)
      else $error("bit count not cleared while enable high");
   a_edge_count_step: assert property (fall_edge |=> bit_count_reg == $past(bit_count_reg) + 4'h1)
      else $error("falling edge did not advance bit count");
   a_commit_sixteenth: assert property (word_done |=> write_commit_out)
      else $error("sixteenth edge did not commit");
   a_no_partial_commit: assert property (!word_done |=> !write_commit_out)
      else $error("commit without a whole word");
   a_word_wrap: assert property (word_done && !pins_s.enable_n |=> bit_count_reg == 4'h0)
      else $error("count did not wrap for next word");
   a_field_store: assert property (word_done && !hw_clear_reg && slot_hit[3]
      && (slot_hit[2:0] != SLOT_RESET_CTRL) |=>
      config_regs_out[$past(slot_hit[2:0])] == last_word_reg[DATA_W-1:0])
      else $error("committed data not stored at its address");
   a_hw_reset_clear: assert property (hw_clear_reg |=> config_regs_out == '0)
      else $error("reset pin did not restore defaults");
   a_soft_reset_clear: assert property (write_commit_out
      && last_word_reg[15:11] == ADDR_RESET_CTRL
      && last_word_reg[SOFT_RESET_BIT] |-> config_regs_out == '0)
      else $error("soft reset did not clear registers");
   a_effect_time: assert property (word_done |-> ##[1:EFFECT_MAX] write_commit_out)
      else $error("write took effect too late");
   a_override_mode: assert property (
      config_regs_out[SLOT_OUT_OPTIONS][OVERRIDE_BIT] |->
      active_mode_out == adcsp_mode_fields(config_regs_out[SLOT_OUT_OPTIONS]))
      else $error("override set but register modes not applied");
   a_pin_power_down: assert property (pdn_pin_s |=> global_power_down_out)
      else $error("power-down pin did not force power-down");
   a_idle_shift_hold: assert property (pins_s.enable_n |=> $stable(shift_reg))
      else $error("shift path moved while enable high");
   a_count_hold: assert property (!fall_edge && !pins_s.enable_n |=>
      $stable(bit_count_reg))
      else $error("bit count moved without a falling edge");
   a_shift_capture: assert property (fall_edge |=> shift_reg == $past(word_now))
      else $error("data bit not shifted in on falling edge");
   a_commit_single: assert property (write_commit_out |=> !write_commit_out)
      else $error("commit pulse longer than one cycle");
   a_unmapped_keep: assert property (word_done && !slot_hit[3] && !hw_clear_reg |=>
      $stable(config_regs_out))
      else $error("unmapped address changed a register");
   a_soft_bit_low: assert property (!config_regs_out[SLOT_RESET_CTRL][SOFT_RESET_BIT])
      else $error("soft reset bit did not clear itself");
   a_pin_mode_follow: assert property (
      !config_regs_out[SLOT_OUT_OPTIONS][OVERRIDE_BIT] |-> active_mode_out == $past(pin_mode_s))
      else $error("pin modes not applied without override");
   a_pdn_combined: assert property (
      global_power_down_out ==
      ($past(pdn_pin_s) | config_regs_out[SLOT_RESET_CTRL][GLOBAL_PDN_BIT]))
      else $error("power-down output not pin or register bit");
endmodule : adcsp_config_port
`default_nettype wire

// *** testbench/adcsp_host_model.sv ***
// host model driving the serial configuration pins
`timescale 1ns/10ps
`default_nettype none
module adcsp_host_model
   import adcsp_pkg::*;
(
   input wire logic clk_in,
   output var adcsp_serial_pins_t pins_out
);
   // enable high, shift clock idle high, data low
   initial pins_out = 3'b110;

   // shifts n bits msb first; hi and lo are clock phases in system cycles
   task automatic shift(input logic [31:0] bits, input int n, input int hi, input int lo,
                        input logic quiet);
      pins_out.enable_n <= quiet;
      repeat (3) @(posedge clk_in);
      for (int i = n - 1; i >= 0; i--) begin
         pins_out.data <= bits[i];
         pins_out.shift_clk <= 1'b1;
         repeat (hi) @(posedge clk_in);
         pins_out.shift_clk <= 1'b0;
         repeat (lo) @(posedge clk_in);
      end
      // released data line shows the inverse of its last value
      pins_out.enable_n <= 1'b1;
      pins_out.shift_clk <= 1'b1;
      pins_out.data <= ~pins_out.data;
      repeat (3) @(posedge clk_in);
   endtask : shift
endmodule : adcsp_host_model
`default_nettype wire

// *** testbench/adc_serial_config_port_bench.sv ***
// self-checking bench of the serial configuration port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module adc_serial_config_port_bench
   import adcsp_pkg::*;
;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   adcsp_serial_pins_t pins;
   logic hw_reset_in = 1'b0;
   logic pdn_pin = 1'b0;
   adcsp_out_mode_t pin_mode = '0;
   logic [NUM_REGS-1:0][DATA_W-1:0] regs;
   adcsp_out_mode_t mode;
   logic gpd;
   logic commit;
   logic [NUM_REGS-1:0][DATA_W-1:0] exp_regs = '0;
   logic [10:0] d;
   int fail_count = 0;
   int checks_done = 0;
   int commits = 0;
   int base = 0;
   int cycles = 0;
   int seed = 44;
   logic [4:0] addr_tab [8] = '{5'h00, 5'h04, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h11};

   always #5 clk_in = ~clk_in;

   adcsp_host_model host (.clk_in(clk_in), .pins_out(pins));

   adcsp_config_port uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .serial_pins_in(pins),
      .hw_reset_in(hw_reset_in), .power_down_pin_in(pdn_pin), .pin_mode_in(pin_mode),
      .config_regs_out(regs), .active_mode_out(mode), .global_power_down_out(gpd),
      .write_commit_out(commit));

   always @(posedge clk_in) if (commit === 1'b1) commits++;

   function automatic adcsp_out_mode_t exp_mode(input logic [10:0] w, input adcsp_out_mode_t p);
      return w[10] ? {w[7:4], w[2:0]} : p;
   endfunction : exp_mode

   // bits that each register uses; all others are written as zero
   function automatic logic [10:0] used_bits(input logic [4:0] a);
      case (a)
         5'h00: return 11'h43f;
         5'h04: return 11'h03f;
         5'h0a: return 11'h2e0;
         5'h0c: return 11'h707;
         5'h0d: return 11'h4f7;
         5'h11: return 11'h61f;
         default: return 11'h7ff;
      endcase
   endfunction : used_bits

   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up

   task automatic chk_all();
      `CHK("regs", exp_regs, regs)
      `CHK("mode", exp_mode(exp_regs[5], pin_mode), mode)
      `CHK("pdn", pdn_pin | exp_regs[0][0], gpd)
   endtask : chk_all

   task automatic settle(input int add);
      repeat (3) @(posedge clk_in);
      `CHK("commits", base + add, commits)
      chk_all();
   endtask : settle

   // one word in its own enable pulse, expectation kept in the shadow copy
   task automatic wr(input logic [4:0] a, input logic [10:0] v, input int hi, input int lo);
      base = commits;
      host.shift({16'h0, a, v}, 16, hi, lo, 1'b0);
      for (int s = 0; s < 8; s++) if (addr_tab[s] == a) exp_regs[s] = v;
      if (a == 5'h00 && v[10]) exp_regs = '0;
      settle(1);
   endtask : wr

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         wrap_up();
      end
   end

   initial begin
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk_all();
      // random words to every mapped address, balanced 4/4 and unbalanced 3/5 shift clock phases
      for (int k = 0; k < 24; k++) begin
         pin_mode <= 7'($random(seed));
         pdn_pin <= 1'($random(seed));
         d = 11'($random(seed)) & used_bits(addr_tab[k % 8]);
         if (k % 8 == 0) d[10] = 1'b0;
         if (k / 8 == 1) wr(addr_tab[k % 8], d, 3, 5);
         else wr(addr_tab[k % 8], d, 4, 4);
      end
      wr(5'h0d, (11'h400 | 11'($random(seed))) & used_bits(5'h0d), 4, 4);
      wr(5'h1f, 11'h7ff, 4, 4);
      // two words in one enable pulse
      base = commits;
      host.shift({5'h0b, 11'h2a5, 5'h0c, 11'h503}, 32, 4, 4, 1'b0);
      exp_regs[3] = 11'h2a5;
      exp_regs[4] = 11'h503;
      settle(2);
      // trailing seven bits dropped, next pulse starts with an address
      base = commits;
      host.shift({9'h0, 5'h0a, 11'h2a0, 7'h13}, 23, 4, 4, 1'b0);
      exp_regs[2] = 11'h2a0;
      settle(1);
      wr(5'h04, 11'h023, 4, 4);
      // shift clock with enable high is ignored
      base = commits;
      host.shift(32'hffff, 16, 4, 4, 1'b1);
      settle(0);
      pdn_pin <= 1'b1;
      wr(5'h00, 11'h400, 4, 4);
      pdn_pin <= 1'b0;
      wr(5'h00, 11'h001, 4, 4);
      wr(5'h10, 11'h5b7, 5, 3);
      // supply wait shortened, reset pin pulse of 20 ns, 60 ns before the next enable
      repeat (20) @(posedge clk_in);
      hw_reset_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      hw_reset_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      exp_regs = '0;
      base = commits;
      settle(0);
      wr(5'h11, 11'h605, 4, 4);
      wrap_up();
   end
endmodule : adc_serial_config_port_bench
`default_nettype wire
